// ==== rtl/nvip_cell.v ====
`timescale 1ns/1ps
// pending/active state of one interrupt
module nvip_cell (
  clk,
  nrst,
  line,
  pulse_mode,
  set_pend,
  clr_pend,
  enter,
  leave,
  pend,
  act
);
  input wire clk;
  input wire nrst;
  input wire line; // synchronised interrupt input
  input wire pulse_mode; // 1 pulse, 0 level
  input wire set_pend; // software or trigger set
  input wire clr_pend; // software clear
  input wire enter; // core enters service routine
  input wire leave; // core returns from service routine
  output reg pend;
  output reg act;
  reg line_d_r; // previous line for edge detect
  reg pend_nxt;
  reg act_nxt;
  wire rise;

  assign rise = line & ~line_d_r;

  // next state; sets are applied last so they win over clears
  always @* begin
    pend_nxt = pend;
    act_nxt = act;
    if (enter) begin
      pend_nxt = 1'b0;
      act_nxt = 1'b1;
    end else if (leave) begin
      act_nxt = 1'b0;
      if (!pulse_mode) begin
        pend_nxt = line;
      end else begin
        pend_nxt = pend;
      end
    end
    if (clr_pend) begin
      // active part untouched
      if (!pulse_mode) begin
        if (!line) pend_nxt = 1'b0;
      end else begin
        pend_nxt = 1'b0;
      end
    end
    // level input pends when not active
    if (!pulse_mode && line && !act_nxt) pend_nxt = 1'b1;
    // in pulse mode a rising edge always latches, also while active
    if (pulse_mode && rise) pend_nxt = 1'b1;
    if (set_pend) pend_nxt = 1'b1;
  end

  // state flops
  always @(posedge clk) begin
    if (!nrst) begin
      pend <= 1'b0;
      act <= 1'b0;
      line_d_r <= 1'b0;
    end else begin
      pend <= pend_nxt;
      act <= act_nxt;
      line_d_r <= line;
    end
  end
endmodule

// ==== rtl/nvip_defines.vh ====
`ifndef NVIP_DEFINES_VH
`define NVIP_DEFINES_VH
// register word offsets (byte addresses)
`define NVIP_OFF_TRIGGER 8'h00
`define NVIP_OFF_CONFIG 8'h04
`define NVIP_OFF_SET_ENABLE 8'h08
`define NVIP_OFF_CLR_ENABLE 8'h0c
`define NVIP_OFF_SET_PEND 8'h10
`define NVIP_OFF_CLR_PEND 8'h14
`define NVIP_OFF_PEND 8'h18
`define NVIP_OFF_ACTIVE 8'h1c
`define NVIP_OFF_TYPE 8'h20
// trigger number field
`define NVIP_TRIG_MSB 8
`define NVIP_TRIG_LSB 0
`define NVIP_TRIG_MAX 9'h1df
// permit bit position in configuration register
`define NVIP_PERMIT_BIT 1
`define NVIP_PERMIT_RST 1'b0
`define NVIP_ENABLE_RST 1'b0
`define NVIP_TYPE_RST 1'b0
`endif

// ==== rtl/nvip_sync.v ====
`timescale 1ns/1ps
// two-stage synchroniser for interrupt lines from peripherals
module nvip_sync #(
  parameter W = 1
) (
  clk,
  nrst,
  din,
  dout
);
  input wire clk;
  input wire nrst;
  input wire [W-1:0] din;
  output reg [W-1:0] dout;
  reg [W-1:0] meta_r; // first stage, read only by dout

  // two flops in series
  always @(posedge clk) begin
    if (!nrst) begin
      meta_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule

// ==== rtl/nvip_top.v ====
`timescale 1ns/1ps
`include "nvip_defines.vh"
// Notes on behaviour
// - trigger write pends interrupt number bits 8:0
// - unprivileged trigger only when permit bit set
// - permit bit changed by privileged writes only
// - one trigger register for both security states
// - level and pulse inputs both supported
// - pulse inputs sampled on clock, latched pending
// - service entry clears pending, sets active
// - level return: pending if asserted, else inactive
// - asserted input pends when not active
// - rising edge makes interrupt pending
// - software set bit makes interrupt pending
// - pulse while active: pending and active
// - no pulse while active: inactive on return
// - level clear: unchanged if asserted, else inactive
// - pulse clear: pending to inactive, both to active
// - disabled interrupt may still become pending
// - only enabled pending interrupts offered to core
// - clear pending never alters active state
module nvip_top #(
  parameter N = 32 // number of interrupts, up to 480
) (
  clk,
  nrst,
  irq_in,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_priv,
  reg_rdata,
  core_enter,
  core_leave,
  core_num,
  irq_pend,
  irq_act,
  irq_en,
  irq_req
);
  input wire clk;
  input wire nrst;
  input wire [N-1:0] irq_in; // peripheral lines, asynchronous
  input wire [7:0] reg_addr; // byte address
  input wire [31:0] reg_wdata;
  input wire reg_wr; // write strobe
  input wire reg_rd; // read strobe
  input wire reg_priv; // 1 privileged access
  output reg [31:0] reg_rdata; // valid cycle after read strobe
  input wire core_enter; // pulse: entering service routine
  input wire core_leave; // pulse: returning from service routine
  input wire [8:0] core_num; // interrupt number for enter/leave
  output wire [N-1:0] irq_pend; // pending per interrupt
  output wire [N-1:0] irq_act; // active per interrupt
  output wire [N-1:0] irq_en; // enable per interrupt
  output wire [N-1:0] irq_req; // pending and enabled

  localparam NW = (N + 31) / 32; // words per bit array
  localparam [8:0] NUM_TOP = N - 1; // highest implemented number

  reg permit_r; // unprivileged trigger permit
  reg [N-1:0] en_r; // enable bits
  reg [N-1:0] pulse_r; // 1 pulse type, 0 level type
  reg [N-1:0] en_nxt;
  reg [N-1:0] set_vec; // per-interrupt software set
  reg [N-1:0] clr_vec; // per-interrupt software clear
  reg [31:0] rdata_nxt;
  wire [N-1:0] line_s; // synchronised inputs
  wire [N-1:0] enter_vec;
  wire [N-1:0] leave_vec;
  wire [NW*32-1:0] wmask; // write data spread to array width
  wire [NW*32-1:0] pend_w;
  wire [NW*32-1:0] act_w;
  wire [NW*32-1:0] en_w;
  wire [NW*32-1:0] type_w;
  wire [8:0] trig_num;
  wire trig_ok;
  integer i;
  genvar k; // bit index of the word-wide views

  assign trig_num = reg_wdata[`NVIP_TRIG_MSB:`NVIP_TRIG_LSB];
  // one shared copy, no security banking
  assign trig_ok = reg_wr && (reg_addr == `NVIP_OFF_TRIGGER)
    && (reg_priv || permit_r)
    && (trig_num <= `NVIP_TRIG_MAX) && (trig_num <= NUM_TOP);

  // spread write data and state bits to whole words bit by bit
  // avoids a zero-width pad when N is a multiple of 32
  generate
    for (k = 0; k < NW * 32; k = k + 1) begin : gen_pad
      if (k < 32) begin : gen_wbit
        assign wmask[k] = reg_wdata[k]; // first word carries write data
      end else begin : gen_wzero
        assign wmask[k] = 1'b0; // higher words not reachable by software
      end
      if (k < N) begin : gen_sbit
        assign pend_w[k] = irq_pend[k];
        assign act_w[k] = irq_act[k];
        assign en_w[k] = en_r[k];
        assign type_w[k] = pulse_r[k];
      end else begin : gen_szero
        // unimplemented interrupt numbers read as zero
        assign pend_w[k] = 1'b0;
        assign act_w[k] = 1'b0;
        assign en_w[k] = 1'b0;
        assign type_w[k] = 1'b0;
      end
    end
  endgenerate

  // input synchronisers for all peripheral lines
  nvip_sync #(
    .W(N)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .din(irq_in),
    .dout(line_s)
  );

  // decode software set and clear pending writes
  always @* begin
    set_vec = {N{1'b0}};
    clr_vec = {N{1'b0}};
    for (i = 0; i < N; i = i + 1) begin
      if (reg_wr && reg_addr == `NVIP_OFF_SET_PEND && wmask[i]) begin
        set_vec[i] = 1'b1;
      end
      if (trig_ok && trig_num == i[8:0]) begin
        set_vec[i] = 1'b1;
      end
      if (reg_wr && reg_addr == `NVIP_OFF_CLR_PEND && wmask[i]) begin
        clr_vec[i] = 1'b1;
      end
    end
  end

  // enable register set/clear
  always @* begin
    en_nxt = en_r;
    if (reg_wr && reg_addr == `NVIP_OFF_SET_ENABLE) begin
      en_nxt = en_r | wmask[N-1:0];
    end else if (reg_wr && reg_addr == `NVIP_OFF_CLR_ENABLE) begin
      en_nxt = en_r & ~wmask[N-1:0];
    end
  end

  // configuration and enable flops
  always @(posedge clk) begin
    if (!nrst) begin
      permit_r <= `NVIP_PERMIT_RST;
      en_r <= {N{`NVIP_ENABLE_RST}};
      pulse_r <= {N{`NVIP_TYPE_RST}};
    end else begin
      en_r <= en_nxt;
      if (reg_wr && reg_addr == `NVIP_OFF_CONFIG && reg_priv) begin
        permit_r <= reg_wdata[`NVIP_PERMIT_BIT];
      end
      if (reg_wr && reg_addr == `NVIP_OFF_TYPE) begin
        pulse_r <= wmask[N-1:0];
      end
    end
  end

  // per-interrupt state cells, entry/return decoded by number
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gen_cell
      assign enter_vec[g] = core_enter && (core_num == g);
      assign leave_vec[g] = core_leave && (core_num == g);
      nvip_cell u_cell (
        .clk(clk),
        .nrst(nrst),
        .line(line_s[g]),
        .pulse_mode(pulse_r[g]),
        .set_pend(set_vec[g]),
        .clr_pend(clr_vec[g]),
        .enter(enter_vec[g]),
        .leave(leave_vec[g]),
        .pend(irq_pend[g]),
        .act(irq_act[g])
      );
    end
  endgenerate

  assign irq_en = en_r;
  assign irq_req = irq_pend & en_r;

  // read mux; trigger register is write-only and reads zero
  always @* begin
    rdata_nxt = 32'h00000000;
    case (reg_addr)
      `NVIP_OFF_CONFIG: rdata_nxt[`NVIP_PERMIT_BIT] = permit_r;
      `NVIP_OFF_SET_ENABLE: rdata_nxt = en_w[31:0];
      `NVIP_OFF_CLR_ENABLE: rdata_nxt = en_w[31:0];
      `NVIP_OFF_SET_PEND: rdata_nxt = pend_w[31:0];
      `NVIP_OFF_CLR_PEND: rdata_nxt = pend_w[31:0];
      `NVIP_OFF_PEND: rdata_nxt = pend_w[31:0];
      `NVIP_OFF_ACTIVE: rdata_nxt = act_w[31:0];
      `NVIP_OFF_TYPE: rdata_nxt = type_w[31:0];
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // read data register, one cycle after strobe
  always @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule

// ==== testbench/interrupt_pending_logic_bench.sv ====
`timescale 1ns/1ps
module interrupt_pending_logic_bench;
  reg clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, reg_priv = 0, core_enter = 0, core_leave = 0;
  reg [7:0] reg_addr = 0;
  reg [31:0] reg_wdata = 0, lvl = 0, fire = 0, rd_v;
  reg [8:0] core_num = 0;
  wire [31:0] irq_in, reg_rdata, irq_pend, irq_act, irq_en, irq_req;
  integer bad_count = 0, compares = 0, i;
  reg [72:0] rows [0:9]; // addr, priv, data, expected pending
  initial forever #20 clk = ~clk;
  ipl_periph #(.N(32)) i_src (.clk(clk), .lvl(lvl), .fire(fire), .irq_in(irq_in));
  nvip_top #(.N(32)) i_dut (.clk(clk), .nrst(nrst), .irq_in(irq_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_priv(reg_priv),
    .reg_rdata(reg_rdata), .core_enter(core_enter), .core_leave(core_leave),
    .core_num(core_num), .irq_pend(irq_pend), .irq_act(irq_act), .irq_en(irq_en),
    .irq_req(irq_req));
  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [63:0] seen, input [63:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one-cycle bus write, state settles by the next falling edge
  task wr(input [7:0] a, input [31:0] d, input p);
    begin
      @(posedge clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= d; reg_priv <= p;
      @(posedge clk); reg_wr <= 0;
      @(negedge clk);
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk); reg_rd <= 1; reg_addr <= a;
      @(posedge clk); reg_rd <= 0;
      @(negedge clk); rd_v = reg_rdata;
    end
  endtask
  // core entry (e=1) or return (e=0) for interrupt n
  task core(input e, input [8:0] n);
    begin
      @(posedge clk); core_enter <= e; core_leave <= !e; core_num <= n;
      @(posedge clk); core_enter <= 0; core_leave <= 0;
      @(negedge clk);
    end
  endtask
  task setl(input [31:0] d);
    begin
      @(posedge clk); lvl <= d;
      repeat (4) @(negedge clk);
    end
  endtask
  // one-clock pulse, then bounded wait for pending
  task pls(input [4:0] k);
    integer j;
    begin
      @(posedge clk); fire <= 32'h1 << k;
      @(posedge clk); fire <= 0;
      @(negedge clk);
      for (j = 0; j < 8 && irq_pend[k] !== 1'b1; j++) @(negedge clk);
      if (irq_pend[k] !== 1'b1) begin
        bad_count = bad_count + 1;
        tally_and_finish;
      end
    end
  endtask
  initial begin
    rows[0] = {8'h10, 1'b1, 32'h1, 32'h1}; // set pending while disabled
    rows[1] = {8'h14, 1'b1, 32'h1, 32'h0}; // level clear with line low
    rows[2] = {8'h00, 1'b1, 32'h5, 32'h20}; // privileged trigger
    rows[3] = {8'h00, 1'b1, 32'h1e0, 32'h20}; // number 480 ignored
    rows[4] = {8'h14, 1'b1, 32'h20, 32'h0};
    rows[5] = {8'h00, 1'b0, 32'h3, 32'h0}; // unprivileged, no permit
    rows[6] = {8'h04, 1'b0, 32'h2, 32'h0}; // unprivileged permit write
    rows[7] = {8'h00, 1'b0, 32'h3, 32'h0}; // still refused
    rows[8] = {8'h04, 1'b1, 32'h2, 32'h0}; // privileged permit
    rows[9] = {8'h00, 1'b0, 32'h203, 32'h8}; // reserved bits ignored
    repeat (11) @(posedge clk);
    @(negedge clk);
    chk("rst", {irq_pend | irq_act | irq_en, reg_rdata}, 64'h0);
    @(posedge clk);
    nrst <= 1;
    for (i = 0; i < 10; i++) begin
      wr(rows[i][72:65], rows[i][63:32], rows[i][64]);
      chk("pend", irq_pend, rows[i][31:0]);
    end
    wr(8'h14, 32'h8, 1);
    $display("end table");
    wr(8'h08, 32'h3, 1); wr(8'h0c, 32'h1, 1); wr(8'h10, 32'h6, 1);
    chk("req", irq_req, 32'h2);
    chk("en_o", irq_en, 32'h2);
    rd(8'h08); chk("en", rd_v, 32'h2);
    wr(8'h14, 32'h6, 1);
    $display("end enable");
    setl(32'h10); chk("lvl", irq_pend, 32'h10);
    wr(8'h14, 32'h10, 1); chk("lclr", irq_pend, 32'h10);
    setl(0); core(1, 4); chk("ent", {irq_act, irq_pend}, {32'h10, 32'h0});
    setl(32'h10); chk("lact", irq_pend, 32'h0);
    core(0, 4); chk("lret", {irq_act, irq_pend}, {32'h0, 32'h10});
    setl(0); wr(8'h14, 32'h10, 1); chk("lidle", irq_pend, 32'h0);
    $display("end level");
    wr(8'h20, 32'h40, 1); pls(6); core(1, 6); pls(6);
    chk("pa", {irq_act, irq_pend}, {32'h40, 32'h40});
    rd(8'h1c); chk("ract", rd_v, 32'h40);
    rd(8'h18); chk("rpend", rd_v, 32'h40);
    wr(8'h14, 32'h40, 1); chk("pclr", {irq_act, irq_pend}, {32'h40, 32'h0});
    pls(6); core(0, 6); chk("pret", {irq_act, irq_pend}, {32'h0, 32'h40});
    wr(8'h14, 32'h40, 1); chk("pclr2", irq_pend, 32'h0);
    core(1, 6); core(0, 6); chk("pidle", {irq_act, irq_pend}, 64'h0);
    rd(8'h40); chk("unmap", rd_v, 32'h0);
    rd(8'h20); chk("type", rd_v, 32'h40);
    $display("end pulse");
    // reset in mid-run clears the held state
    wr(8'h10, 32'h1, 1);
    @(posedge clk); nrst <= 0;
    @(posedge clk); nrst <= 1;
    @(negedge clk); chk("mrst", {irq_pend | irq_act | irq_en, reg_rdata}, 64'h0);
    rd(8'h04); chk("permrst", rd_v, 32'h0);
    wr(8'h00, 32'h3, 0); chk("utrig", irq_pend, 32'h0);
    wr(8'h10, 32'h1, 1); chk("postrst", irq_pend, 32'h1);
    $display("end reset");
    tally_and_finish;
  end
endmodule

// ==== testbench/ipl_checker_assertions.sv ====
`timescale 1ns/1ps
// watches the top ports for the pending/active rules
module ipl_checker #(parameter N = 32) (
  input wire clk, nrst, reg_wr, reg_rd, reg_priv, core_enter, core_leave,
  input wire [N-1:0] irq_in, irq_pend, irq_act, irq_en, irq_req,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata, reg_rdata,
  input wire [8:0] core_num
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_REQ: assert property (irq_req == (irq_pend & irq_en))
    else $error("req");
  AST_ENTER: assert property (core_enter && core_num < N |=> irq_act[$past(core_num)])
    else $error("enter");
  AST_LEAVE: assert property (core_leave && !core_enter && core_num < N
    |=> !irq_act[$past(core_num)]) else $error("leave");
  AST_CLR_ACT: assert property (reg_wr && reg_addr == 8'h14 && !core_enter && !core_leave
    |=> irq_act == $past(irq_act)) else $error("clr act");
  AST_SETP: assert property (reg_wr && reg_addr == 8'h10
    |=> (irq_pend & $past(reg_wdata[N-1:0])) == $past(reg_wdata[N-1:0])) else $error("setp");
  AST_TRIG: assert property (reg_wr && reg_addr == 8'h00 && reg_priv && reg_wdata[8:0] < N
    |=> irq_pend[$past(reg_wdata[8:0])]) else $error("trig");
  AST_READ: assert property (reg_rd && reg_addr == 8'h18
    |=> reg_rdata[N-1:0] == $past(irq_pend)) else $error("read");
  AST_ACT_CAUSE: assert property ((irq_act & ~$past(irq_act)) != 0 |-> $past(core_enter))
    else $error("act");
  AST_PEND_CAUSE: assert property ((irq_pend & ~$past(irq_pend)) != 0 |-> $past(reg_wr)
    || ($past(irq_in, 2) | $past(irq_in, 3) | $past(irq_in, 4)) != 0) else $error("pend");
  cover property (core_leave && irq_pend[core_num]);
  cover property (reg_wr && reg_addr == 8'h00 && !reg_priv);
  cover property (core_enter && irq_in != 0);
endmodule
bind nvip_top ipl_checker #(.N(N)) i_chk (.clk(clk), .nrst(nrst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_priv(reg_priv), .core_enter(core_enter), .core_leave(core_leave),
  .irq_in(irq_in), .irq_pend(irq_pend), .irq_act(irq_act), .irq_en(irq_en),
  .irq_req(irq_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .core_num(core_num));

// ==== testbench/ipl_periph.sv ====
`timescale 1ns/1ps
// peripheral sources: held levels plus one-clock pulses
module ipl_periph #(parameter N = 32) (
  input wire clk,
  input wire [N-1:0] lvl,
  input wire [N-1:0] fire,
  output wire [N-1:0] irq_in
);
  reg [N-1:0] pulse_r = '0; // pulse lines, one full clock each
  // a fire request stretches to one whole clock
  always @(posedge clk) begin
    pulse_r <= fire;
  end
  assign irq_in = lvl | pulse_r;
endmodule
